/* File: verification/ctl_bank_tb_top.sv */
`timescale 1ns/10ps

module ctl_bank_tb_top
    import ctl_bank_pkg::*;
;
    logic        core_clk;
    logic        srst;
    logic        power_on_evt;
    logic        ext_wdt_evt;
    logic        pin_wake_evt;
    logic [3:0]  addr;
    logic [7:0]  wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rd_data;
    wire [15:0][7:0] outs;
    logic [7:0]  small_p5;
    int          num_errors;
    int          check_count;

    ctl_bank dut (
        .core_clk(core_clk), .srst(srst), .power_on_evt(power_on_evt),
        .ext_wdt_evt(ext_wdt_evt), .pin_wake_evt(pin_wake_evt), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .port5_direction(outs[0]), .port6_direction(outs[1]),
        .port7_direction(outs[2]), .comparator_timer_a_control(outs[3]),
        .timer_b_c_control(outs[4]), .infrared_carrier_control(outs[5]),
        .port5_pulldown_control(outs[6]), .port6_open_drain_control(outs[7]),
        .port5_pullup_control(outs[8]), .watchdog_wake_control(outs[9]),
        .interrupt_enable_mask(outs[10]), .timer_a_data(outs[11]),
        .timer_b_low_data(outs[12]), .timer_b_high_data(outs[13]),
        .timer_c_data(outs[14]), .low_pulse_width_reload(outs[15])
    );

    // The smaller part differs only in port 5 direction bits 7 and 6.
    ctl_bank #(
        .LARGE_VARIANT(1'b0)
    ) dut_small (
        .core_clk(core_clk), .srst(srst), .power_on_evt(power_on_evt),
        .ext_wdt_evt(ext_wdt_evt), .pin_wake_evt(pin_wake_evt), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(),
        .port5_direction(small_p5), .port6_direction(), .port7_direction(),
        .comparator_timer_a_control(), .timer_b_c_control(), .infrared_carrier_control(),
        .port5_pulldown_control(), .port6_open_drain_control(), .port5_pullup_control(),
        .watchdog_wake_control(), .interrupt_enable_mask(), .timer_a_data(),
        .timer_b_low_data(), .timer_b_high_data(), .timer_c_data(),
        .low_pulse_width_reload()
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Cold values of the larger part, the variant instantiated as dut.
    function automatic byte_t cold(int i);
        case (i)
            0, 1, 6, 7, 8: cold = 8'hff;
            2: cold = 8'h01;
            default: cold = 8'h00;
        endcase
    endfunction : cold

    function automatic byte_t wmask(int i);
        wmask = (i == 2) ? 8'h01 : ((i == 3) ? 8'h3f : 8'hff);
    endfunction : wmask

    // Bit 0 of the pattern differs from the cold value wherever a mask would hide the rest.
    function automatic byte_t pat(int i);
        pat = 8'h5a ^ byte_t'(i);
    endfunction : pat

    task automatic chk(string name, byte_t exp, byte_t got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(logic [3:0] a, byte_t d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd_chk(logic [3:0] a, byte_t exp);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk($sformatf("register %0d", a), exp, rd_data);
    endtask : rd_chk

    task automatic write_all();
        for (int i = 0; i < 16; i++) wr(4'(i), pat(i));
    endtask : write_all

    task automatic check_all(bit kept);
        byte_t expected;
        for (int i = 0; i < 16; i++) begin
            expected = kept ? (pat(i) & wmask(i)) : cold(i);
            rd_chk(4'(i), expected);
            chk($sformatf("output %0d", i), expected, outs[i]);
        end
        chk("small port5_direction", kept ? (pat(0) & 8'h3f) : 8'h3f, small_p5);
    endtask : check_all

    task automatic test_cold();
        check_all(1'b0);
    endtask : test_cold

    task automatic test_wake();
        write_all();
        @(posedge core_clk);
        pin_wake_evt <= 1'b1;
        wr_en <= 1'b1;
        addr <= 4'hb;
        wr_data <= 8'h00;
        @(posedge core_clk);
        pin_wake_evt <= 1'b0;
        wr_en <= 1'b0;
        #1;
        chk("timer_a_data", pat(11), outs[11]);
        check_all(1'b1);
    endtask : test_wake

    task automatic test_power_on();
        write_all();
        @(posedge core_clk);
        power_on_evt <= 1'b1;
        @(posedge core_clk);
        power_on_evt <= 1'b0;
        check_all(1'b0);
    endtask : test_power_on

    task automatic test_ext_wdt();
        write_all();
        @(posedge core_clk);
        ext_wdt_evt <= 1'b1;
        @(posedge core_clk);
        ext_wdt_evt <= 1'b0;
        #1;
        chk("port5_direction", 8'hff, outs[0]);
        check_all(1'b0);
    endtask : test_ext_wdt

    task automatic test_srst();
        write_all();
        @(posedge core_clk);
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        check_all(1'b0);
    endtask : test_srst

    task automatic summarize();
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // The whole sequence needs well under two thousand cycles.
    initial begin
        #20000;
        num_errors++;
        summarize();
    end

    initial begin
        srst = 1'b1;
        {power_on_evt, ext_wdt_evt, pin_wake_evt, wr_en, rd_en} = 5'h00;
        addr = 4'h0;
        wr_data = 8'h00;
        num_errors = 0;
        check_count = 0;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        test_cold();
        test_wake();
        test_power_on();
        test_ext_wdt();
        test_srst();
        summarize();
    end
endmodule : ctl_bank_tb_top

/* File: verilog/ctl_bank.sv */
// Contract
// R1: Power-on and external or watchdog reset load the same values; pin-change wake-up keeps the values it finds, save as R3 says.
// R2: On power-on or external/watchdog reset port5_direction gets 3f (small) or ff (large).
// R3: On wake-up port5_direction keeps bits 5..0; bits 7..6 kept on large, cleared on small.
// R4: port6_direction loads ff on power-on or external/watchdog reset and is kept on wake-up.
// R5: comparator_timer_a_control clears on power-on or external/watchdog reset, kept on wake.
// R6: timer_b_c_control clears on power-on or external/watchdog reset and is kept on wake-up.
// R7: infrared_carrier_control clears on power-on or external/watchdog reset, kept on wake.
// R8: port5_pulldown_control (active low) loads ff on those resets and is kept on wake-up.
// R9: port6_open_drain_control (active low) loads ff on those resets and is kept on wake-up.
// R10: port5_pullup_control (active low) loads ff on those resets and is kept on wake-up.
// R11: watchdog_wake_control clears on those resets and is kept on wake-up.
// R12: interrupt_enable_mask clears on those resets and is kept on wake-up.
// R13: timer_a_data clears on those resets and is kept on wake-up.
// R14: timer_b_low_data and timer_b_high_data clear on those resets and are kept on wake-up.
// R15: timer_c_data clears on those resets and is kept on wake-up.
// R16: low_pulse_width_reload clears on those resets and is kept on wake-up.
// R17: Unimplemented bits of partial registers read as zero and ignore writes.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "ctl_bank_defines.svh"

module ctl_bank
    import ctl_bank_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         srst,
    // Reset events, one-cycle pulses.
    input  wire logic         power_on_evt,
    input  wire logic         ext_wdt_evt,
    input  wire logic         pin_wake_evt,
    // Register port.
    input  wire logic [3:0]   addr,
    input  wire logic [7:0]   wr_data,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic      [7:0]   rd_data,
    // Control outputs.
    output logic      [7:0]   port5_direction,
    output logic      [7:0]   port6_direction,
    output logic      [7:0]   port7_direction,
    output logic      [7:0]   comparator_timer_a_control,
    output logic      [7:0]   timer_b_c_control,
    output logic      [7:0]   infrared_carrier_control,
    output logic      [7:0]   port5_pulldown_control,
    output logic      [7:0]   port6_open_drain_control,
    output logic      [7:0]   port5_pullup_control,
    output logic      [7:0]   watchdog_wake_control,
    output logic      [7:0]   interrupt_enable_mask,
    output logic      [7:0]   timer_a_data,
    output logic      [7:0]   timer_b_low_data,
    output logic      [7:0]   timer_b_high_data,
    output logic      [7:0]   timer_c_data,
    output logic      [7:0]   low_pulse_width_reload
);

    bank_state_t  state;
    bank_state_t  next_state;
    reset_event_t evt;

    // Writable bits per register; masked bits stay zero forever.
    function automatic byte_t write_mask(input logic [3:0] idx);
        case (idx)
            `IDX_P7_DIR:     write_mask = `MASK_P7_DIR; // see R17
            `IDX_CMP_TA_CTL: write_mask = `MASK_CMP_TA; // see R17
            `IDX_P5_DIR:     write_mask = LARGE_VARIANT ? 8'hff : `MASK_P5_DIR_LOW;
            default:         write_mask = 8'hff;
        endcase
    endfunction : write_mask

    // Value loaded by power-on and by external or watchdog reset; they agree bit for bit.
    function automatic byte_t cold_value(input logic [3:0] idx);
        case (idx)
            `IDX_P5_DIR: cold_value = LARGE_VARIANT ? `RST_P5_DIR_LARGE
                                                    : `RST_P5_DIR_SMALL; // see R2
            `IDX_P6_DIR: cold_value = `RST_ALL_ONES; // see R4
            `IDX_P7_DIR: cold_value = `RST_P7_DIR;
            `IDX_P5_PD:  cold_value = `RST_ALL_ONES; // see R8
            `IDX_P6_OD:  cold_value = `RST_ALL_ONES; // see R9
            `IDX_P5_PU:  cold_value = `RST_ALL_ONES; // see R10
            // Controls, enables and timer data all clear. see R5 see R6 see R7 see R11
            // see R12 see R13 see R14 see R15 see R16
            default:     cold_value = `RST_ZERO;
        endcase
    endfunction : cold_value

    // Power-on outranks the other two when events coincide.
    always_comb begin
        if (power_on_evt) begin
            evt = EV_POWER_ON;
        end else if (ext_wdt_evt) begin
            evt = EV_EXT_WDT;
        end else if (pin_wake_evt) begin
            evt = EV_PIN_WAKE;
        end else begin
            evt = EV_NONE;
        end
    end

    always_comb begin
        next_state = state;
        next_state.rd_data = 8'h00;
        case (evt)
            EV_POWER_ON, EV_EXT_WDT: begin
                for (int i = 0; i < 16; i++) begin
                    next_state.regs[i] = cold_value(4'(i)); // see R1
                end
            end
            EV_PIN_WAKE: begin
                // Everything is kept except the small variant's missing port 5 bits.
                next_state.regs[`IDX_P5_DIR] = state.regs[`IDX_P5_DIR]
                                               & write_mask(`IDX_P5_DIR); // see R3
            end
            EV_NONE: begin
                if (wr_en) begin
                    next_state.regs[addr] = wr_data & write_mask(addr); // see R17
                end
            end
            default: begin
                next_state = state;
            end
        endcase
        // A read samples the bank before any same-cycle write lands.
        if (rd_en) begin
            next_state.rd_data = state.regs[addr];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < 16; i++) begin
                state.regs[i] <= cold_value(4'(i));
            end
            state.rd_data <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data                    = state.rd_data;
    assign port5_direction            = state.regs[`IDX_P5_DIR];
    assign port6_direction            = state.regs[`IDX_P6_DIR];
    assign port7_direction            = state.regs[`IDX_P7_DIR];
    assign comparator_timer_a_control = state.regs[`IDX_CMP_TA_CTL];
    assign timer_b_c_control          = state.regs[`IDX_TB_TC_CTL];
    assign infrared_carrier_control   = state.regs[`IDX_IR_CTL];
    assign port5_pulldown_control     = state.regs[`IDX_P5_PD];
    assign port6_open_drain_control   = state.regs[`IDX_P6_OD];
    assign port5_pullup_control       = state.regs[`IDX_P5_PU];
    assign watchdog_wake_control      = state.regs[`IDX_WDT_CTL];
    assign interrupt_enable_mask      = state.regs[`IDX_INT_EN];
    assign timer_a_data               = state.regs[`IDX_TA_DATA];
    assign timer_b_low_data           = state.regs[`IDX_TB_LO];
    assign timer_b_high_data          = state.regs[`IDX_TB_HI];
    assign timer_c_data               = state.regs[`IDX_TC_DATA];
    assign low_pulse_width_reload     = state.regs[`IDX_LPW_RELOAD];

    a_cold_p5_dir: assert property (@(posedge core_clk) disable iff (srst) // see R2
        (power_on_evt || ext_wdt_evt) |=> port5_direction ==
            (LARGE_VARIANT ? 8'hff : 8'h3f))
        else $error("port5 direction wrong after cold reset");

    a_wake_p5_dir: assert property (@(posedge core_clk) disable iff (srst) // see R3
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=>
            port5_direction[5:0] == $past(port5_direction[5:0]) &&
            (LARGE_VARIANT ? port5_direction[7:6] == $past(port5_direction[7:6])
                           : port5_direction[7:6] == 2'b00))
        else $error("port5 direction not kept on wake");

    a_cold_p6_dir: assert property (@(posedge core_clk) disable iff (srst) // see R4
        (power_on_evt || ext_wdt_evt) |=> port6_direction == 8'hff)
        else $error("port6 direction not set on cold reset");

    a_wake_p6_dir: assert property (@(posedge core_clk) disable iff (srst) // see R4
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(port6_direction))
        else $error("port6 direction not kept on wake");

    a_cold_p7_dir: assert property (@(posedge core_clk) disable iff (srst) // see R1
        (power_on_evt || ext_wdt_evt) |=> port7_direction == 8'h01)
        else $error("port7 direction wrong after cold reset");

    a_cold_pulls: assert property (@(posedge core_clk) disable iff (srst) // see R8
        ext_wdt_evt |=> port5_pulldown_control == 8'hff &&
            port6_open_drain_control == 8'hff && port5_pullup_control == 8'hff)
        else $error("active-low pin controls not all ones");

    a_cold_pulldown: assert property (@(posedge core_clk) disable iff (srst) // see R8
        power_on_evt |=> port5_pulldown_control == 8'hff)
        else $error("port5 pull-down control not all ones");

    a_cold_open_drain: assert property (@(posedge core_clk) disable iff (srst) // see R9
        (power_on_evt || ext_wdt_evt) |=> port6_open_drain_control == 8'hff)
        else $error("port6 open-drain control not all ones");

    a_cold_pullup: assert property (@(posedge core_clk) disable iff (srst) // see R10
        (power_on_evt || ext_wdt_evt) |=> port5_pullup_control == 8'hff)
        else $error("port5 pull-up control not all ones");

    a_wake_pulldown: assert property (@(posedge core_clk) disable iff (srst) // see R8
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(port5_pulldown_control))
        else $error("port5 pull-down control not kept on wake");

    a_wake_open_drain: assert property (@(posedge core_clk) disable iff (srst) // see R9
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(port6_open_drain_control))
        else $error("port6 open-drain control not kept on wake");

    a_wake_pullup: assert property (@(posedge core_clk) disable iff (srst) // see R10
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(port5_pullup_control))
        else $error("port5 pull-up control not kept on wake");

    a_cold_ctrl_zero: assert property (@(posedge core_clk) disable iff (srst) // see R5
        power_on_evt |=> comparator_timer_a_control == 8'h00 &&
            timer_b_c_control == 8'h00 && infrared_carrier_control == 8'h00 &&
            watchdog_wake_control == 8'h00)
        else $error("control register not cleared");

    a_cold_cmp_ctl: assert property (@(posedge core_clk) disable iff (srst) // see R5
        ext_wdt_evt |=> comparator_timer_a_control == 8'h00)
        else $error("comparator control not cleared");

    a_wake_cmp_ctl: assert property (@(posedge core_clk) disable iff (srst) // see R5
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(comparator_timer_a_control))
        else $error("comparator control not kept on wake");

    a_cold_tb_tc: assert property (@(posedge core_clk) disable iff (srst) // see R6
        ext_wdt_evt |=> timer_b_c_control == 8'h00)
        else $error("timer b and c control not cleared");

    a_wake_tb_tc: assert property (@(posedge core_clk) disable iff (srst) // see R6
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(timer_b_c_control))
        else $error("timer b and c control not kept on wake");

    a_cold_ir_ctl: assert property (@(posedge core_clk) disable iff (srst) // see R7
        ext_wdt_evt |=> infrared_carrier_control == 8'h00)
        else $error("carrier control not cleared");

    a_wake_ir_ctl: assert property (@(posedge core_clk) disable iff (srst) // see R7
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(infrared_carrier_control))
        else $error("carrier control not kept on wake");

    a_cold_wdt_ctl: assert property (@(posedge core_clk) disable iff (srst) // see R11
        ext_wdt_evt |=> watchdog_wake_control == 8'h00)
        else $error("watchdog control not cleared");

    a_wake_wdt_ctl: assert property (@(posedge core_clk) disable iff (srst) // see R11
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(watchdog_wake_control))
        else $error("watchdog control not kept on wake");

    a_cold_int_zero: assert property (@(posedge core_clk) disable iff (srst) // see R12
        (power_on_evt || ext_wdt_evt) |=> interrupt_enable_mask == 8'h00)
        else $error("interrupt enables not cleared");

    a_wake_int_en: assert property (@(posedge core_clk) disable iff (srst) // see R12
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(interrupt_enable_mask))
        else $error("interrupt enables not kept on wake");

    a_cold_timer_zero: assert property (@(posedge core_clk) disable iff (srst) // see R13
        ext_wdt_evt |=> (timer_a_data | timer_b_low_data | timer_b_high_data |
            timer_c_data | low_pulse_width_reload) == 8'h00)
        else $error("timer data not cleared");

    a_cold_ta_data: assert property (@(posedge core_clk) disable iff (srst) // see R13
        power_on_evt |=> timer_a_data == 8'h00)
        else $error("timer a data not cleared");

    a_wake_ta_data: assert property (@(posedge core_clk) disable iff (srst) // see R13
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(timer_a_data))
        else $error("timer a data not kept on wake");

    a_cold_tb_data: assert property (@(posedge core_clk) disable iff (srst) // see R14
        power_on_evt |=> timer_b_low_data == 8'h00 &&
            timer_b_high_data == 8'h00)
        else $error("timer b data not cleared");

    a_wake_tb_data: assert property (@(posedge core_clk) disable iff (srst) // see R14
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=>
            $stable(timer_b_low_data) && $stable(timer_b_high_data))
        else $error("timer b data not kept on wake");

    a_cold_tc_data: assert property (@(posedge core_clk) disable iff (srst) // see R15
        power_on_evt |=> timer_c_data == 8'h00)
        else $error("timer c data not cleared");

    a_wake_tc_data: assert property (@(posedge core_clk) disable iff (srst) // see R15
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(timer_c_data))
        else $error("timer c data not kept on wake");

    a_cold_lpw_reload: assert property (@(posedge core_clk) disable iff (srst) // see R16
        power_on_evt |=> low_pulse_width_reload == 8'h00)
        else $error("low pulse reload not cleared");

    a_wake_lpw_reload: assert property (@(posedge core_clk) disable iff (srst) // see R16
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(low_pulse_width_reload))
        else $error("low pulse reload not kept on wake");

    a_wake_keeps: assert property (@(posedge core_clk) disable iff (srst) // see R1
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=>
            $stable(interrupt_enable_mask) && $stable(timer_c_data) &&
            $stable(infrared_carrier_control))
        else $error("wake-up altered a kept register");

    a_wake_bank: assert property (@(posedge core_clk) disable iff (srst) // see R1
        (pin_wake_evt && !power_on_evt && !ext_wdt_evt) |=> $stable(state.regs))
        else $error("wake-up altered the register bank");

    a_unused_bits: assert property (@(posedge core_clk) disable iff (srst) // see R17
        port7_direction[7:1] == 7'h00 &&
            comparator_timer_a_control[7:6] == 2'b00)
        else $error("unimplemented bits nonzero");

    a_small_p5_high: assert property (@(posedge core_clk) disable iff (srst) // see R3
        LARGE_VARIANT || port5_direction[7:6] == 2'b00)
        else $error("small part port5 direction high bits nonzero");

    a_write_p7_mask: assert property (@(posedge core_clk) disable iff (srst) // see R17
        (wr_en && !power_on_evt && !ext_wdt_evt && !pin_wake_evt && addr == `IDX_P7_DIR)
            |=> port7_direction == ($past(wr_data) & 8'h01))
        else $error("port7 direction write not masked");

    a_write_cmp_mask: assert property (@(posedge core_clk) disable iff (srst) // see R17
        (wr_en && !power_on_evt && !ext_wdt_evt && !pin_wake_evt && addr == `IDX_CMP_TA_CTL)
            |=> comparator_timer_a_control == ($past(wr_data) & 8'h3f))
        else $error("comparator control write not masked");

    a_write_int_en: assert property (@(posedge core_clk) disable iff (srst)
        (wr_en && !power_on_evt && !ext_wdt_evt && !pin_wake_evt && addr == `IDX_INT_EN)
            |=> interrupt_enable_mask == $past(wr_data))
        else $error("interrupt enable write lost");

    a_read_data: assert property (@(posedge core_clk) disable iff (srst) // see R16
        (rd_en && addr == 4'hf) |=> rd_data == $past(low_pulse_width_reload))
        else $error("read data mismatch");

    a_read_p5_dir: assert property (@(posedge core_clk) disable iff (srst) // see R2
        (rd_en && addr == `IDX_P5_DIR) |=> rd_data == $past(port5_direction))
        else $error("port5 direction read mismatch");

    a_read_int_en: assert property (@(posedge core_clk) disable iff (srst) // see R12
        (rd_en && addr == `IDX_INT_EN) |=> rd_data == $past(interrupt_enable_mask))
        else $error("interrupt enable read mismatch");

    a_read_idle: assert property (@(posedge core_clk) disable iff (srst)
        !rd_en |=> rd_data == 8'h00)
        else $error("read data not zero without a read");

endmodule : ctl_bank

/* File: verilog/ctl_bank_defines.svh */
`ifndef CTL_BANK_DEFINES_SVH
`define CTL_BANK_DEFINES_SVH

`define IDX_P5_DIR      4'h0
`define IDX_P6_DIR      4'h1
`define IDX_P7_DIR      4'h2
`define IDX_CMP_TA_CTL  4'h3
`define IDX_TB_TC_CTL   4'h4
`define IDX_IR_CTL      4'h5
`define IDX_P5_PD       4'h6
`define IDX_P6_OD       4'h7
`define IDX_P5_PU       4'h8
`define IDX_WDT_CTL     4'h9
`define IDX_INT_EN      4'ha
`define IDX_TA_DATA     4'hb
`define IDX_TB_LO       4'hc
`define IDX_TB_HI       4'hd
`define IDX_TC_DATA     4'he
`define IDX_LPW_RELOAD  4'hf

`define RST_P5_DIR_SMALL 8'h3f
`define RST_P5_DIR_LARGE 8'hff
`define RST_ALL_ONES     8'hff
`define RST_ZERO         8'h00
`define RST_P7_DIR       8'h01
`define MASK_P7_DIR      8'h01
`define MASK_CMP_TA      8'h3f
`define MASK_P5_DIR_LOW  8'h3f

`endif

/* File: verilog/ctl_bank_pkg.sv */
package ctl_bank_pkg;

    typedef enum logic [1:0] {
        EV_NONE,
        EV_POWER_ON,
        EV_EXT_WDT,
        EV_PIN_WAKE
    } reset_event_t;

    typedef logic [7:0] byte_t;

    typedef struct packed {
        byte_t [15:0] regs;
        byte_t        rd_data;
    } bank_state_t;

endpackage : ctl_bank_pkg
